// ### src/ethernet_irq_flag_logic.sv
// Interrupt flag and enable logic of the Ethernet controller.
// Assumes register decode, receive, DMA and MAC engines drive events.
// How it works
// - Receive-pending flag bit 6 follows packet counter being nonzero.
// - Copy-done flag bit 5 sets when copy or checksum finishes.
// - Link-change flag bit 4 sets on PHY signal, clears on PHY flag read.
// - Receive-error flag bit 0 sets on drop from full buffer or count 255.
// - Bit 2 reserved written zero by host; bit 7 reads zero.
// - PHY enable bit 4 enables link-change source.
// - PHY enable bit 1 gates all PHY sources; others reserved zero.
// - PHY link flag bit 4 sets on link change, clears on read.
// - PHY global flag bit 2 sets on enabled PHY event, clears on read.
// - Receive-error flag holds until host clear or reset.
// - Receive error drives pin only with its enable and global enable.
// - Transmit error on collisions, late collision, deferral timeout.
// - Oversize frame without huge enables aborts with transmit error.
// - Transmit error pulses pin low one clock when enabled.
// - Abort clears request, sets abort flag, writes status at end plus 1.
// - Full duplex raises transmit error only for oversize.
// - Transmit error sets transmit-end flag in same cycle.
// - Transmit-end flag sets when transmit request falls.
// - Success is request fell without host clear and no abort.
// - Pin low when any enabled flag other than transmit error set and global enable on.
// - Pin stays low until causing flags cleared or masked.
`default_nettype none
module ethernet_irq_flag_logic (
   input  wire logic                        sys_clk_i,
   input  wire logic                        arst_n_i,
   input  wire irq_flag_pkg::ctrl_access_t  ctrl_acc_i,
   input  wire irq_flag_pkg::phy_access_t   phy_acc_i,
   input  wire irq_flag_pkg::tx_events_t    tx_ev_i,
   input  wire irq_flag_pkg::tx_cfg_t       tx_cfg_i,
   input  wire logic                        tx_start_i,
   input  wire logic                        tx_host_cancel_i,
   input  wire logic                        tx_abort_clr_i,
   input  wire logic [12:0]                 tx_end_pointer_i,
   input  wire logic                        pkt_rx_ok_i,
   input  wire logic                        pkt_rx_no_space_i,
   input  wire logic                        packet_decrement_i,
   input  wire logic                        copy_done_i,
   input  wire logic                        phy_link_event_i,
   output logic [7:0]                       ctrl_flags_o,
   output logic [7:0]                       ctrl_enables_o,
   output logic [15:0]                      phy_enables_o,
   output logic [15:0]                      phy_flags_o,
   output logic [7:0]                       packet_counter_o,
   output logic                             tx_request_o,
   output logic                             tx_abort_flag_o,
   output logic                             tx_success_o,
   output logic                             tsv_write_o,
   output logic [12:0]                      tsv_addr_o,
   output logic                             irq_n_o
);
   import irq_flag_pkg::*;

   // ==========================================================
   // Registers
   // ==========================================================
   logic [7:0]  flags_r, flags_nxt;
   logic [7:0]  en_r;
   logic [15:0] phy_en_r;
   logic        plink_r, pglob_r;
   logic [7:0]  pkt_cnt_r, pkt_cnt_nxt;
   logic        tx_req_r, abort_r, cancelled_r, success_r;
   logic        tsv_wr_r;
   logic [12:0] tsv_addr_r;
   logic        txerr_pulse_r;

   // ==========================================================
   // Transmit abort decode
   // ==========================================================
   wire huge_ok = tx_cfg_i.huge_frame_enable |
                  (tx_cfg_i.per_packet_override &
                   tx_cfg_i.per_packet_huge_enable);
   wire oversize_abort = tx_ev_i.oversize & ~huge_ok;
   wire share_abort = ~tx_cfg_i.full_duplex &
                      (tx_ev_i.excess_coll | tx_ev_i.late_coll |
                       tx_ev_i.coll_after_64 |
                       (tx_ev_i.forever_a_timeout & ~tx_cfg_i.forever_a));
   wire tx_abort   = tx_req_r & (oversize_abort | share_abort);
   wire tx_done    = tx_req_r & tx_ev_i.done & ~tx_abort;
   wire tx_cancel  = tx_req_r & tx_host_cancel_i & ~tx_abort & ~tx_done;
   wire tx_fall    = tx_abort | tx_done | tx_cancel;

   // ==========================================================
   // Receive counter
   // ==========================================================
   wire cnt_full  = (pkt_cnt_r == PKT_CNT_MAX);
   wire rx_drop   = pkt_rx_no_space_i | (pkt_rx_ok_i & cnt_full);
   wire rx_inc    = pkt_rx_ok_i & ~cnt_full & ~pkt_rx_no_space_i;
   wire rx_dec    = packet_decrement_i & (pkt_cnt_r != PKT_CNT_RST);

   always_comb begin
      pkt_cnt_nxt = pkt_cnt_r;
      if (rx_inc && !rx_dec) begin
         pkt_cnt_nxt = pkt_cnt_r + 8'h01;
      end else if (rx_dec && !rx_inc) begin
         pkt_cnt_nxt = pkt_cnt_r - 8'h01;
      end
   end

   // ==========================================================
   // PHY flags
   // ==========================================================
   wire phy_gate  = phy_en_r[PHY_GEN_BIT] & phy_en_r[PHY_LNK_BIT];
   wire phy_read  = phy_acc_i.flag_rd;
   wire plink_nxt = phy_link_event_i | (plink_r & ~phy_read);
   wire pglob_nxt = (phy_link_event_i & phy_gate) |
                    (pglob_r & ~phy_read);
   wire link_set  = phy_link_event_i & phy_gate;

   // ==========================================================
   // Controller flags
   // ==========================================================
   wire [7:0] set_ev = {1'b0, 1'b0, copy_done_i, link_set,
                        tx_fall, 1'b0, tx_abort, rx_drop};
   wire [7:0] clr_mask = ctrl_acc_i.flag_clr ? ctrl_acc_i.data : 8'h00;
   wire [7:0] sw_set = ctrl_acc_i.flag_set ?
                       (ctrl_acc_i.data & 8'h2B) : 8'h00;
   wire [7:0] hw_clr = {1'b0, 1'b0, 1'b0, phy_read, 4'h0};

   always_comb begin
      flags_nxt = (flags_r & ~clr_mask & ~hw_clr) | sw_set | set_ev;
      flags_nxt[RXPEND_BIT] = (pkt_cnt_nxt != PKT_CNT_RST);
      flags_nxt[RSVD_BIT]   = 1'b0;
      flags_nxt[GLOBAL_BIT] = 1'b0;
   end

   // ==========================================================
   // Interrupt pin
   // ==========================================================
   wire [7:0] lvl_mask = 8'h79;
   wire any_lvl = |(flags_r & en_r & lvl_mask);
   wire txerr_en = en_r[TXERR_BIT];
   wire pin_act = en_r[GLOBAL_BIT] & (any_lvl | txerr_pulse_r);

   // ==========================================================
   // Sequential
   // ==========================================================
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flags_r       <= FLAGS_RST;
         en_r          <= ENABLES_RST;
         phy_en_r      <= PHY_EN_RST;
         plink_r       <= 1'b0;
         pglob_r       <= 1'b0;
         pkt_cnt_r     <= PKT_CNT_RST;
         txerr_pulse_r <= 1'b0;
      end else begin
         flags_r       <= flags_nxt;
         plink_r       <= plink_nxt;
         pglob_r       <= pglob_nxt;
         pkt_cnt_r     <= pkt_cnt_nxt;
         txerr_pulse_r <= tx_abort & txerr_en;
         if (ctrl_acc_i.en_wr) begin
            en_r <= ctrl_acc_i.data & 8'hFB;
         end
         if (phy_acc_i.en_wr) begin
            phy_en_r <= phy_acc_i.data & PHY_EN_MASK;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_req_r    <= 1'b0;
         abort_r     <= 1'b0;
         cancelled_r <= 1'b0;
         success_r   <= 1'b0;
         tsv_wr_r    <= 1'b0;
         tsv_addr_r  <= 13'h0000;
      end else begin
         tsv_wr_r <= tx_abort;
         if (tx_abort) begin
            tsv_addr_r <= tx_end_pointer_i + 13'h0001;
         end
         if (tx_fall) begin
            tx_req_r <= 1'b0;
         end else if (tx_start_i) begin
            tx_req_r <= 1'b1;
         end
         if (tx_abort) begin
            abort_r <= 1'b1;
         end else if (tx_abort_clr_i) begin
            abort_r <= 1'b0;
         end
         if (tx_start_i && !tx_req_r) begin
            cancelled_r <= 1'b0;
            success_r   <= 1'b0;
         end else if (tx_fall) begin
            cancelled_r <= tx_cancel;
            success_r   <= tx_done & ~abort_r;
         end
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign ctrl_flags_o     = flags_r;
   assign ctrl_enables_o   = en_r;
   assign phy_enables_o    = phy_en_r;
   assign phy_flags_o      = {11'h000, plink_r, 1'b0, pglob_r, 2'b00};
   assign packet_counter_o = pkt_cnt_r;
   assign tx_request_o     = tx_req_r;
   assign tx_abort_flag_o  = abort_r;
   assign tx_success_o     = success_r & ~cancelled_r;
   assign tsv_write_o      = tsv_wr_r;
   assign tsv_addr_o       = tsv_addr_r;
   assign irq_n_o          = ~pin_act;
endmodule
`default_nettype wire

// ### include/irq_flag_pkg.sv
// Package for the interrupt flag logic: bit positions, reset values,
// register access structs.
// Assumes a register access engine outside that decodes host commands.
`default_nettype none
package irq_flag_pkg;
   // Controller flag register bit positions
   localparam int RXERR_BIT  = 0;
   localparam int TXERR_BIT  = 1;
   localparam int RSVD_BIT   = 2;
   localparam int TXEND_BIT  = 3;
   localparam int LINK_BIT   = 4;
   localparam int COPY_BIT   = 5;
   localparam int RXPEND_BIT = 6;
   localparam int GLOBAL_BIT = 7;
   // PHY enable / flag bit positions
   localparam int PHY_GEN_BIT  = 1;
   localparam int PHY_GFL_BIT  = 2;
   localparam int PHY_LNK_BIT  = 4;
   // Reset values
   localparam logic [7:0]  FLAGS_RST   = 8'h00;
   localparam logic [7:0]  ENABLES_RST = 8'h00;
   localparam logic [15:0] PHY_EN_RST  = 16'h0000;
   localparam logic [7:0]  PKT_CNT_RST = 8'h00;
   localparam logic [7:0]  PKT_CNT_MAX = 8'hFF;
   // Writable enables in PHY enable register
   localparam logic [15:0] PHY_EN_MASK = 16'h0012;
   // Transmit abort timing
   localparam real FOREVER_A_LIMIT_MS = 2.4287;
   localparam real CLK_MHZ        = 20.0;
   localparam int  FOREVER_A_CYCLES   = int'(FOREVER_A_LIMIT_MS * 1000.0 * CLK_MHZ);
   localparam int  LATE_COL_BYTES = 64;

   // Host access to controller registers
   typedef struct packed {
      logic       flag_clr;     // bit field clear of flag register
      logic       flag_set;     // bit field set of flag register
      logic       en_wr;        // write of enable register
      logic [7:0] data;
   } ctrl_access_t;

   // Host access to PHY registers
   typedef struct packed {
      logic        en_wr;
      logic        flag_rd;
      logic [15:0] data;
   } phy_access_t;

   // Transmit engine events
   typedef struct packed {
      logic excess_coll;
      logic late_coll;
      logic coll_after_64;
      logic forever_a_timeout;
      logic oversize;
      logic done;
   } tx_events_t;

   // Transmit control settings
   typedef struct packed {
      logic full_duplex;
      logic forever_a;
      logic huge_frame_enable;
      logic per_packet_override;
      logic per_packet_huge_enable;
   } tx_cfg_t;
endpackage
`default_nettype wire

// ### testbench/irq_flag_properties.sv
// Checker for the interrupt flag and pin relations at the block's ports.
// Assumes it is bound to ethernet_irq_flag_logic by the bind at the foot.
`default_nettype none
module irq_flag_properties
   import irq_flag_pkg::*;
(
   input wire logic                       sys_clk_i,
   input wire logic                       arst_n_i,
   input wire irq_flag_pkg::ctrl_access_t ctrl_acc_i,
   input wire irq_flag_pkg::phy_access_t  phy_acc_i,
   input wire logic [12:0]                tx_end_pointer_i,
   input wire logic                       phy_link_event_i,
   input wire logic [7:0]                 ctrl_flags_o,
   input wire logic [7:0]                 ctrl_enables_o,
   input wire logic [15:0]                phy_enables_o,
   input wire logic [15:0]                phy_flags_o,
   input wire logic [7:0]                 packet_counter_o,
   input wire logic                       tx_request_o,
   input wire logic                       tx_abort_flag_o,
   input wire logic                       tsv_write_o,
   input wire logic [12:0]                tsv_addr_o,
   input wire logic                       irq_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Pin causes and assertions
   // Transmit error drives the pin as a one-clock pulse, not a level
   wire logic lvl = ctrl_enables_o[7] &&
                    (|(ctrl_flags_o & ctrl_enables_o & 8'h79));
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence tx_abort_seq;
      $fell(tx_request_o) && $rose(ctrl_flags_o[1]);
   endsequence
   rx_pend_follow_a : assert property (ctrl_flags_o[6] == (|packet_counter_o))
      else $error("pending flag does not follow counter");
   reserved_zero_a : assert property (!ctrl_flags_o[7] && !ctrl_flags_o[2])
      else $error("reserved flag bit set");
   phy_en_bits_a : assert property ((phy_enables_o & 16'hFFED) == 16'h0000)
      else $error("reserved phy enable bit set");
   rx_err_hold_a : assert property (ctrl_flags_o[0] &&
      !(ctrl_acc_i.flag_clr && ctrl_acc_i.data[0]) |=> ctrl_flags_o[0])
      else $error("receive error flag lost");
   tx_end_fall_a : assert property ($fell(tx_request_o) |-> ctrl_flags_o[3])
      else $error("transmit end flag missing");
   tx_err_end_a : assert property ($rose(ctrl_flags_o[1]) |-> ctrl_flags_o[3])
      else $error("transmit error without transmit end");
   abort_side_a : assert property (tx_abort_seq |-> tx_abort_flag_o &&
      tsv_write_o && tsv_addr_o == $past(tx_end_pointer_i) + 13'h0001)
      else $error("abort side effects wrong");
   pin_level_a : assert property (lvl |-> !irq_n_o)
      else $error("pin high with enabled flag");
   pin_cause_a : assert property (!irq_n_o |-> lvl || ($rose(ctrl_flags_o[1])
      && ctrl_enables_o[1] && ctrl_enables_o[7]))
      else $error("pin low without cause");
   phy_read_clr_a : assert property (phy_acc_i.flag_rd && !phy_link_event_i
      |=> (phy_flags_o & 16'h0014) == 16'h0000 && !ctrl_flags_o[4])
      else $error("phy flag read did not clear");
   phy_link_set_a : assert property (phy_link_event_i && phy_enables_o[4]
      && phy_enables_o[1] |=> phy_flags_o[4] && phy_flags_o[2] && ctrl_flags_o[4])
      else $error("link change not flagged");
endmodule
bind ethernet_irq_flag_logic irq_flag_properties chk_i (.sys_clk_i, .arst_n_i,
   .ctrl_acc_i, .phy_acc_i, .tx_end_pointer_i, .phy_link_event_i, .ctrl_flags_o,
   .ctrl_enables_o, .phy_enables_o, .phy_flags_o, .packet_counter_o,
   .tx_request_o, .tx_abort_flag_o, .tsv_write_o, .tsv_addr_o, .irq_n_o);
`default_nettype wire

// ### testbench/host_irq_monitor.sv
// Host side model: counts falling edges of the interrupt pin.
// Assumes the pin is sampled on the block's clock.
`default_nettype none
module host_irq_monitor (
   input  wire logic  sys_clk_i,
   input  wire logic  arst_n_i,
   input  wire logic  irq_n_i,
   output logic [7:0] fall_count_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic irq_n_r;
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_n_r <= 1'b1;
         fall_count_o <= 8'h00;
      end else begin
         irq_n_r <= irq_n_i;
         fall_count_o <= fall_count_o + {7'h00, irq_n_r & ~irq_n_i};
      end
   end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Testbench for the interrupt flag logic, with a host pin monitor.
// Assumes the checker is bound in from its own file.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import irq_flag_pkg::*;
   logic              sys_clk_i = 1'b0;
   logic              arst_n_i = 1'b0;
   logic [42:0]       stim = '0;
   tx_cfg_t           cfg = '0;
   wire logic [7:0]   pl;
   wire ctrl_access_t ca;
   wire phy_access_t  pa;
   wire tx_events_t   ev;
   logic [7:0]        flags, ens, cnt, fall;
   logic [15:0]       phy_en, phy_fl;
   logic [12:0]       tsv_a;
   logic              req, abrt, succ, tsv_w, irq_n;
   int                bad_count = 0;
   int                total_checks = 0;
   // Pulses: 7 start, 6 cancel, 5 abort clear, 4 rx ok, 3 no space,
   // 2 decrement, 1 copy done, 0 link change
   assign {pl, ca, pa, ev} = stim;
   ethernet_irq_flag_logic uut (.sys_clk_i, .arst_n_i, .ctrl_acc_i(ca),
      .phy_acc_i(pa), .tx_ev_i(ev), .tx_cfg_i(cfg), .tx_start_i(pl[7]),
      .tx_host_cancel_i(pl[6]), .tx_abort_clr_i(pl[5]),
      .tx_end_pointer_i(13'h1FFF), .pkt_rx_ok_i(pl[4]),
      .pkt_rx_no_space_i(pl[3]), .packet_decrement_i(pl[2]),
      .copy_done_i(pl[1]), .phy_link_event_i(pl[0]), .ctrl_flags_o(flags),
      .ctrl_enables_o(ens), .phy_enables_o(phy_en), .phy_flags_o(phy_fl),
      .packet_counter_o(cnt), .tx_request_o(req), .tx_abort_flag_o(abrt),
      .tx_success_o(succ), .tsv_write_o(tsv_w), .tsv_addr_o(tsv_a),
      .irq_n_o(irq_n));
   host_irq_monitor host (.sys_clk_i, .arst_n_i, .irq_n_i(irq_n),
      .fall_count_o(fall));
   // ==========================================================
   // Access and comparison tasks
   task automatic go(input logic [7:0] p, input logic [10:0] c,
                     input logic [17:0] h, input logic [5:0] e);
      @(posedge sys_clk_i);
      stim <= {p, c, h, e};
      @(posedge sys_clk_i);
      stim <= '0;
      #1;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      repeat (4000) @(posedge sys_clk_i);
      bad_count++;
      print_verdict();
   end
   // ==========================================================
   // Scenarios
   initial begin
      repeat (12) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      #1;
      chk({flags, ens, phy_en, cnt, irq_n}, {8'h00, 8'h00, 16'h0000, 8'h00, 1'b1});
      go(8'h00, 11'h1FF, 18'h2_FFFF, 6'h00);
      chk({ens, phy_en, irq_n}, {8'hFB, 16'h0012, 1'b1});
      go(8'h10, 11'h000, 18'h0_0000, 6'h00);
      chk({cnt, flags, irq_n}, {8'h01, 8'h40, 1'b0});
      go(8'h04, 11'h000, 18'h0_0000, 6'h00);
      chk({cnt, flags, irq_n}, {8'h00, 8'h00, 1'b1});
      go(8'h02, 11'h000, 18'h0_0000, 6'h00);
      chk(flags, 8'h20);
      go(8'h00, 11'h420, 18'h0_0000, 6'h00);
      go(8'h08, 11'h000, 18'h0_0000, 6'h00);
      chk({flags, irq_n}, {8'h01, 1'b0});
      repeat (5) @(posedge sys_clk_i);
      go(8'h00, 11'h1FA, 18'h0_0000, 6'h00);
      chk({flags, irq_n}, {8'h01, 1'b1});
      go(8'h08, 11'h401, 18'h0_0000, 6'h00);
      chk(flags, 8'h01);
      go(8'h00, 11'h401, 18'h0_0000, 6'h00);
      go(8'h00, 11'h1FB, 18'h0_0000, 6'h00);
      chk(flags, 8'h00);
      repeat (255) go(8'h10, 11'h000, 18'h0_0000, 6'h00);
      go(8'h10, 11'h000, 18'h0_0000, 6'h00);
      chk({cnt, flags}, {8'hFF, 8'h41});
      repeat (255) go(8'h04, 11'h000, 18'h0_0000, 6'h00);
      chk({cnt, flags}, {8'h00, 8'h01});
      go(8'h00, 11'h401, 18'h0_0000, 6'h00);
      go(8'h01, 11'h000, 18'h0_0000, 6'h00);
      chk({phy_fl, flags, irq_n}, {16'h0014, 8'h10, 1'b0});
      go(8'h00, 11'h000, 18'h1_0000, 6'h00);
      chk({phy_fl, flags, irq_n}, {16'h0000, 8'h00, 1'b1});
      go(8'h00, 11'h000, 18'h2_0000, 6'h00);
      go(8'h01, 11'h000, 18'h0_0000, 6'h00);
      chk({phy_fl, flags}, {16'h0010, 8'h00});
      go(8'h00, 11'h000, 18'h1_0000, 6'h00);
      go(8'h00, 11'h000, 18'h2_0012, 6'h00);
      for (int i = 0; i < 5; i++) begin
         go(8'h80, 11'h000, 18'h0_0000, 6'h00);
         go(8'h00, 11'h000, 18'h0_0000, 6'h20 >> i);
         chk({req, abrt, tsv_w, flags, tsv_a, irq_n}, {3'b011, 8'h0A, 13'h0000, 1'b0});
         go(8'h20, 11'h40A, 18'h0_0000, 6'h00);
         chk({abrt, flags}, {1'b0, 8'h00});
      end
      @(posedge sys_clk_i);
      cfg <= 5'h14;
      go(8'h80, 11'h000, 18'h0_0000, 6'h00);
      go(8'h00, 11'h000, 18'h0_0000, 6'h3E);
      chk({req, flags}, {1'b1, 8'h00});
      go(8'h00, 11'h000, 18'h0_0000, 6'h01);
      chk({req, abrt, succ, flags}, {3'b001, 8'h08});
      go(8'h00, 11'h408, 18'h0_0000, 6'h00);
      go(8'h80, 11'h000, 18'h0_0000, 6'h00);
      go(8'h40, 11'h000, 18'h0_0000, 6'h00);
      chk({req, succ, flags}, {2'b00, 8'h08});
      go(8'h00, 11'h408, 18'h0_0000, 6'h00);
      go(8'h00, 11'h182, 18'h0_0000, 6'h00);
      @(posedge sys_clk_i);
      cfg <= 5'h12;
      go(8'h80, 11'h000, 18'h0_0000, 6'h00);
      go(8'h00, 11'h000, 18'h0_0000, 6'h02);
      chk({flags, irq_n}, {8'h0A, 1'b0});
      @(posedge sys_clk_i);
      #1;
      chk(irq_n, 1'b1);
      go(8'h00, 11'h40A, 18'h0_0000, 6'h00);
      chk({fall, irq_n}, {8'h0D, 1'b1});
      print_verdict();
   end
endmodule
`default_nettype wire
